//--- src/timer16_pkg.sv
// constants, state type and mode decode for the 16-bit timer with capture
// How it works
// - counter clears, counts up or down
// - count low read latches count high
// - high write latches; low write loads both
// - clock source zero stops the count
// - count is readable and writable while stopped
// - bus write to count beats counting
// - waveform mode picks the counting sequence
// - wrap flag set where mode defines
// - trigger edge copies count into capture
// - capture flag set with the copy
// - flag with enable requests interrupt; ack clears
// - writing one clears capture flag
// - capture low read latches capture high
// - capture value writable only as top
// - pin trigger, comparator when select set
// - source switch may capture; clear after
// - filter changes after four equal samples
// - filter enable inserts four-cycle filter
// - filter samples on the system clock
// - capture input off when capture is top
// - each capture overwrites the previous value
// - bottom is zero, maximum is all ones
// - top is fixed, compare A or capture
package timer16_pkg;
    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
    localparam logic [7:0] ADDR_CAP_LO = 8'h10;
    localparam logic [7:0] ADDR_CAP_HI = 8'h14;
    localparam logic [7:0] ADDR_CMPA_LO = 8'h18;
    localparam logic [7:0] ADDR_CMPA_HI = 8'h1C;
    localparam logic [7:0] ADDR_FLAGS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h24;
    localparam logic [7:0] ADDR_CMP_CTRL = 8'h28;
    localparam int CTRLB_WGM_LO = 3;
    localparam int CTRLB_EDGE = 6;
    localparam int CTRLB_FILT = 7;
    localparam int FLAG_WRAP = 0;
    localparam int FLAG_CAP = 5;
    localparam int CMP_SELECT = 2;
    localparam int CMP_LEVEL = 5;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    typedef struct packed {
        logic wb_ack;
        logic [7:0] rd_data;
        logic [7:0] tmp;
        logic [15:0] cnt;
        dir_t dir;
        logic [3:0] wgm;
        logic [2:0] cs;
        logic edge_rise;
        logic filt_en;
        logic [15:0] icr;
        logic [15:0] ocra;
        logic wrap_flag;
        logic cap_flag;
        logic wrap_ie;
        logic cap_ie;
        logic comparator_capture_select;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [1:0] pin_sync;
        logic [1:0] cmp_sync;
        logic [3:0] filt_shift;
        logic filt_out;
        logic edge_prev;
    } state_t;
    localparam state_t STATE_RESET = '0;

    function automatic logic [15:0] mode_top(input logic [3:0] wgm,
        input logic [15:0] ocra, input logic [15:0] icr);
        case (wgm)
            4'h1, 4'h5: mode_top = TOP_8BIT;
            4'h2, 4'h6: mode_top = TOP_9BIT;
            4'h3, 4'h7: mode_top = TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: mode_top = ocra;
            4'h8, 4'hA, 4'hC, 4'hE: mode_top = icr;
            default: mode_top = COUNT_MAX;
        endcase
    endfunction : mode_top

    function automatic logic mode_dual(input logic [3:0] wgm);
        mode_dual = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
    endfunction : mode_dual

    function automatic logic mode_icr_top(input logic [3:0] wgm);
        mode_icr_top = (wgm inside {4'h8, 4'hA, 4'hC, 4'hE});
    endfunction : mode_icr_top

    // clear-on-top modes whose wrap flag still marks the maximum
    function automatic logic mode_ctc(input logic [3:0] wgm);
        mode_ctc = (wgm inside {4'h0, 4'h4, 4'hC, 4'hD});
    endfunction : mode_ctc
endpackage : timer16_pkg

//--- src/timer16_counter_input_capture.sv
// 16-bit timer counter with input capture behind a classic Wishbone slave
//
// Chosen here: the register addresses and register access over Wishbone.
module timer16_counter_input_capture #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [3:0] i_prescale_tick,
    input wire logic i_ext_clock_pin,
    input wire logic i_capture_input_pin,
    input wire logic i_comparator_output,
    input wire logic i_capture_irq_ack,
    input wire logic i_wrap_irq_ack,
    output logic o_capture_irq,
    output logic o_wrap_irq,
    output logic o_count_top,
    output logic o_count_bottom
);
    timer16_pkg::state_t s;
    timer16_pkg::state_t next_s;
    logic req;
    logic wr;
    logic rd;
    logic [7:0] wdat;
    logic [15:0] top;
    logic icr_top;
    logic ext_rise;
    logic ext_fall;
    logic tick;
    logic src;
    logic lvl;
    logic cap_event;
    logic cnt_wr;
    logic [15:0] cnt_wr_val;
    logic [7:0] cnt_high;
    logic flags_wr;
    logic wrap_set;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
        input logic [7:0] off);
        hit = (a[7:2] == off[7:2]) && ((a >> 8) == '0);
    endfunction : hit

    // sources 2..5 come from the shared prescaler, 6 and 7 from the pin
    function automatic logic tick_of(input logic [2:0] cs,
        input logic [3:0] pre, input logic rise, input logic fall);
        case (cs)
            3'h0: tick_of = 1'b0;
            3'h1: tick_of = 1'b1;
            3'h2: tick_of = pre[0];
            3'h3: tick_of = pre[1];
            3'h4: tick_of = pre[2];
            3'h5: tick_of = pre[3];
            3'h6: tick_of = fall;
            3'h7: tick_of = rise;
            default: tick_of = 1'b0;
        endcase
    endfunction : tick_of

    assign req = i_wb_cyc & i_wb_stb & ~s.wb_ack;
    assign wr = req & i_wb_we & i_wb_sel[0];
    assign rd = req & ~i_wb_we;
    assign wdat = i_wb_dat[7:0];
    assign top = timer16_pkg::mode_top(s.wgm, s.ocra, s.icr);
    assign icr_top = timer16_pkg::mode_icr_top(s.wgm);
    assign ext_rise = s.ext_sync[1] & ~s.ext_prev;
    assign ext_fall = ~s.ext_sync[1] & s.ext_prev;
    assign tick = tick_of(s.cs, i_prescale_tick, ext_rise, ext_fall);
    // the source mux sits after both synchronisers, so a switch can
    // itself look like an edge; software clears the flag afterwards
    assign src = s.comparator_capture_select ? s.cmp_sync[1] : s.pin_sync[1];
    assign lvl = s.filt_en ? s.filt_out : src;
    assign cap_event = (lvl != s.edge_prev) && (lvl == s.edge_rise)
        && !icr_top;
    assign cnt_wr = wr && hit(i_wb_adr, timer16_pkg::ADDR_CNT_LO);
    assign cnt_wr_val = {s.tmp, wdat};
    assign cnt_high = s.cnt[15:8];
    assign flags_wr = wr && hit(i_wb_adr, timer16_pkg::ADDR_FLAGS);

    always_comb
    begin
        next_s = s;
        wrap_set = 1'b0;
        next_s.wb_ack = req;
        next_s.ext_sync = {s.ext_sync[0], i_ext_clock_pin};
        next_s.ext_prev = s.ext_sync[1];
        next_s.pin_sync = {s.pin_sync[0], i_capture_input_pin};
        next_s.cmp_sync = {s.cmp_sync[0], i_comparator_output};
        // the filter runs every system clock, whatever the tick does
        next_s.filt_shift = {s.filt_shift[2:0], src};
        if (&s.filt_shift)
        begin
            next_s.filt_out = 1'b1;
        end
        else if (~|s.filt_shift)
        begin
            next_s.filt_out = 1'b0;
        end
        next_s.edge_prev = lvl;

        // a dropped tick also drops its wrap flag
        if (tick && !cnt_wr)
        begin
            if (timer16_pkg::mode_dual(s.wgm))
            begin
                if (s.dir == timer16_pkg::DIR_UP)
                begin
                    if (s.cnt >= top)
                    begin
                        next_s.dir = timer16_pkg::DIR_DOWN;
                        if (s.cnt != timer16_pkg::COUNT_BOTTOM)
                        begin
                            next_s.cnt = s.cnt - 16'h0001;
                        end
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 16'h0001;
                    end
                end
                else if (s.cnt == timer16_pkg::COUNT_BOTTOM)
                begin
                    next_s.dir = timer16_pkg::DIR_UP;
                    next_s.cnt = s.cnt + 16'h0001;
                    wrap_set = 1'b1;
                end
                else
                begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
            else
            begin
                next_s.dir = timer16_pkg::DIR_UP;
                if (s.cnt == top)
                begin
                    next_s.cnt = timer16_pkg::COUNT_BOTTOM;
                end
                else
                begin
                    next_s.cnt = s.cnt + 16'h0001;
                end
                if (timer16_pkg::mode_ctc(s.wgm))
                begin
                    if (s.cnt == timer16_pkg::COUNT_MAX)
                    begin
                        wrap_set = 1'b1;
                    end
                end
                else if (s.cnt == top)
                begin
                    wrap_set = 1'b1;
                end
            end
        end

        if (rd)
        begin
            next_s.rd_data = 8'h00;
            if (hit(i_wb_adr, timer16_pkg::ADDR_CTRL_A))
            begin
                next_s.rd_data[1:0] = s.wgm[1:0];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CTRL_B))
            begin
                next_s.rd_data[2:0] = s.cs;
                next_s.rd_data[timer16_pkg::CTRLB_WGM_LO +: 2] = s.wgm[3:2];
                next_s.rd_data[timer16_pkg::CTRLB_EDGE] = s.edge_rise;
                next_s.rd_data[timer16_pkg::CTRLB_FILT] = s.filt_en;
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CNT_LO))
            begin
                next_s.rd_data = s.cnt[7:0];
                next_s.tmp = s.cnt[15:8];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CNT_HI) ||
                hit(i_wb_adr, timer16_pkg::ADDR_CAP_HI))
            begin
                next_s.rd_data = s.tmp;
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CAP_LO))
            begin
                next_s.rd_data = s.icr[7:0];
                next_s.tmp = s.icr[15:8];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CMPA_LO))
            begin
                next_s.rd_data = s.ocra[7:0];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CMPA_HI))
            begin
                next_s.rd_data = s.ocra[15:8];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_FLAGS))
            begin
                next_s.rd_data[timer16_pkg::FLAG_WRAP] = s.wrap_flag;
                next_s.rd_data[timer16_pkg::FLAG_CAP] = s.cap_flag;
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_IRQ_EN))
            begin
                next_s.rd_data[timer16_pkg::FLAG_WRAP] = s.wrap_ie;
                next_s.rd_data[timer16_pkg::FLAG_CAP] = s.cap_ie;
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CMP_CTRL))
            begin
                next_s.rd_data[timer16_pkg::CMP_SELECT] = s.comparator_capture_select;
                next_s.rd_data[timer16_pkg::CMP_LEVEL] = s.cmp_sync[1];
            end
        end

        if (wr)
        begin
            if (hit(i_wb_adr, timer16_pkg::ADDR_CTRL_A))
            begin
                next_s.wgm[1:0] = wdat[1:0];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CTRL_B))
            begin
                next_s.cs = wdat[2:0];
                next_s.wgm[3:2] = wdat[timer16_pkg::CTRLB_WGM_LO +: 2];
                next_s.edge_rise = wdat[timer16_pkg::CTRLB_EDGE];
                next_s.filt_en = wdat[timer16_pkg::CTRLB_FILT];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CNT_HI) ||
                hit(i_wb_adr, timer16_pkg::ADDR_CAP_HI) ||
                hit(i_wb_adr, timer16_pkg::ADDR_CMPA_HI))
            begin
                next_s.tmp = wdat;
            end
            else if (cnt_wr)
            begin
                next_s.cnt = cnt_wr_val;
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CAP_LO))
            begin
                if (icr_top)
                begin
                    next_s.icr = {s.tmp, wdat};
                end
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CMPA_LO))
            begin
                next_s.ocra = {s.tmp, wdat};
            end
            else if (flags_wr)
            begin
                if (wdat[timer16_pkg::FLAG_WRAP])
                begin
                    next_s.wrap_flag = 1'b0;
                end
                if (wdat[timer16_pkg::FLAG_CAP])
                begin
                    next_s.cap_flag = 1'b0;
                end
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_IRQ_EN))
            begin
                next_s.wrap_ie = wdat[timer16_pkg::FLAG_WRAP];
                next_s.cap_ie = wdat[timer16_pkg::FLAG_CAP];
            end
            else if (hit(i_wb_adr, timer16_pkg::ADDR_CMP_CTRL))
            begin
                next_s.comparator_capture_select = wdat[timer16_pkg::CMP_SELECT];
            end
        end

        // service acks come before event sets so a new event is kept
        if (i_capture_irq_ack)
        begin
            next_s.cap_flag = 1'b0;
        end
        if (i_wrap_irq_ack)
        begin
            next_s.wrap_flag = 1'b0;
        end
        // applied after both clears so a wrap in the clearing cycle stays
        if (wrap_set)
        begin
            next_s.wrap_flag = 1'b1;
        end
        if (cap_event)
        begin
            next_s.icr = s.cnt;
            next_s.cap_flag = 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            s <= timer16_pkg::STATE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_wb_ack = s.wb_ack;
    assign o_wb_dat = {24'h000000, s.rd_data};
    assign o_capture_irq = s.cap_flag & s.cap_ie;
    assign o_wrap_irq = s.wrap_flag & s.wrap_ie;
    assign o_count_top = (s.cnt == top);
    assign o_count_bottom = (s.cnt == timer16_pkg::COUNT_BOTTOM);

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    property p_ack_single;
        req |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("ack not a single cycle");

    property p_stop_hold;
        (s.cs == 3'h0) && !cnt_wr |=> $stable(s.cnt);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("counter moved while stopped");

    property p_write_low;
        cnt_wr |=> s.cnt == $past(cnt_wr_val);
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("count write lost or merged with a tick");

    property p_read_latch;
        rd && hit(i_wb_adr, timer16_pkg::ADDR_CNT_LO)
            |=> s.tmp == $past(cnt_high);
    endproperty
    a_read_latch: assert property (p_read_latch)
        else $error("count high not latched on low read");

    property p_capture;
        cap_event |=> s.cap_flag && (s.icr == $past(s.cnt));
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture copy or flag missing");

    property p_icr_top_off;
        icr_top |-> !cap_event;
    endproperty
    a_icr_top_off: assert property (p_icr_top_off)
        else $error("capture while capture value is top");

    sequence s_src_high4;
        src [*4];
    endsequence
    sequence s_src_low4;
        !src [*4];
    endsequence
    property p_filter;
        (s_src_high4 |=> ##1 s.filt_out) and
        (s_src_low4 |=> ##1 !s.filt_out);
    endproperty
    a_filter: assert property (p_filter)
        else $error("filter did not follow four equal samples");

    property p_flag_clear;
        flags_wr && wdat[timer16_pkg::FLAG_CAP] && !cap_event
            |=> !s.cap_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("capture flag not cleared by writing one");

    property p_wrap_normal;
        tick && !cnt_wr && (s.wgm == 4'h0) &&
            (s.cnt == timer16_pkg::COUNT_MAX)
            |=> s.wrap_flag && (s.cnt == timer16_pkg::COUNT_BOTTOM);
    endproperty
    a_wrap_normal: assert property (p_wrap_normal)
        else $error("no wrap at maximum in normal mode");
endmodule : timer16_counter_input_capture

//--- tb/cpu_model.sv
// cpu side model: classic wishbone single cycles over the 8-bit data lane
module cpu_model (
    input wire logic i_clock,
    input wire logic [31:0] i_dat,
    input wire logic i_ack,
    output logic o_cyc,
    output logic o_stb,
    output logic o_we,
    output logic [7:0] o_adr,
    output logic [31:0] o_dat,
    output logic [3:0] o_sel,
    output logic o_hung
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 8'h00;
        o_dat = 32'h0;
        o_sel = 4'h0;
        o_hung = 1'b0;
    end
    // request stands until ack is seen at an edge; a lost ack sets hung
    task automatic xfer(input logic we, input logic [7:0] adr,
        input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge i_clock);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= we;
        o_adr <= adr;
        o_dat <= {24'h0, wd};
        o_sel <= 4'hF;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (i_ack !== 1'b1 && n < 64);
        rd = i_dat[7:0];
        if (i_ack !== 1'b1)
            o_hung <= 1'b1;
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_we <= 1'b0;
    endtask : xfer
    // high byte goes to the shared latch first, low byte commits both
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        logic [7:0] x;
        xfer(1'b1, lo + 8'h04, v[15:8], x);
        xfer(1'b1, lo, v[7:0], x);
    endtask : wr16
    // low byte first so the latch holds the matching high byte
    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        xfer(1'b0, lo, 8'h00, v[7:0]);
        xfer(1'b0, lo + 8'h04, 8'h00, v[15:8]);
    endtask : rd16
endmodule : cpu_model

//--- tb/testbench.sv
// self-checking bench: cpu model on the bus, pins and ticks driven here
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] tick = 4'h0;
    logic ext_pin = 1'b0;
    logic cap_pin = 1'b0;
    logic cmp_out = 1'b0;
    logic cap_ack = 1'b0;
    logic wrap_ack = 1'b0;
    logic cyc, stb, we, ack, hung, cap_irq, wrap_irq, top, bottom;
    logic [7:0] adr;
    logic [7:0] b;
    logic [31:0] wdat, rdat;
    logic [3:0] sel;
    logic [15:0] v;
    int n_errors = 0;
    int check_count = 0;
    always #4 i_clock = ~i_clock;
    cpu_model i_cpu (.i_clock(i_clock), .i_dat(rdat), .i_ack(ack),
        .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_dat(wdat),
        .o_sel(sel), .o_hung(hung));
    timer16_counter_input_capture i_dut (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_prescale_tick(tick),
        .i_ext_clock_pin(ext_pin), .i_capture_input_pin(cap_pin),
        .i_comparator_output(cmp_out), .i_capture_irq_ack(cap_ack),
        .i_wrap_irq_ack(wrap_ack), .o_capture_irq(cap_irq),
        .o_wrap_irq(wrap_irq), .o_count_top(top),
        .o_count_bottom(bottom));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    always @(posedge hung)
    begin
        n_errors++;
        finish_test();
    end
    initial
    begin
        repeat (100000) @(posedge i_clock);
        n_errors++;
        finish_test();
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_cpu.xfer(1'b1, a, d, x);
    endtask : wr
    task automatic rdf(input logic [7:0] exp);
        i_cpu.xfer(1'b0, timer16_pkg::ADDR_FLAGS, 8'h00, b);
        chk({8'h00, b}, {8'h00, exp});
    endtask : rdf
    task automatic rdc(input logic [7:0] lo, input logic [15:0] exp);
        i_cpu.rd16(lo, v);
        chk(v, exp);
    endtask : rdc
    // one tick per two cycles, then an edge so the count has landed
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge i_clock);
            tick[0] <= 1'b1;
            @(posedge i_clock);
            tick[0] <= 1'b0;
        end
        @(posedge i_clock);
    endtask : pulse
    task automatic set_pin(input logic p, input int d);
        @(posedge i_clock);
        cap_pin <= p;
        repeat (d) @(posedge i_clock);
    endtask : set_pin
    initial
    begin
        repeat (12) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rdc(timer16_pkg::ADDR_CNT_LO, 16'h0000);
        chk({14'h0, top, bottom}, 16'h0001);
        $display("test reset done");
        wr(timer16_pkg::ADDR_CTRL_B, 8'h00);
        i_cpu.wr16(timer16_pkg::ADDR_CNT_LO, 16'h1234);
        rdc(timer16_pkg::ADDR_CNT_LO, 16'h1234);
        wr(timer16_pkg::ADDR_CNT_HI, 8'hAB);
        pulse(4);
        rdc(timer16_pkg::ADDR_CNT_LO, 16'h1234);
        i_cpu.xfer(1'b0, 8'h3C, 8'h00, b);
        chk({8'h00, b}, 16'h0000);
        $display("test access done");
        wr(timer16_pkg::ADDR_CTRL_B, 8'h02);
        i_cpu.wr16(timer16_pkg::ADDR_CNT_LO, 16'hFFFE);
        pulse(1);
        chk({15'h0, top}, 16'h0001);
        pulse(1);
        chk({15'h0, bottom}, 16'h0001);
        rdf(8'h01);
        wr(timer16_pkg::ADDR_IRQ_EN, 8'h01);
        chk({15'h0, wrap_irq}, 16'h0001);
        @(posedge i_clock);
        wrap_ack <= 1'b1;
        @(posedge i_clock);
        wrap_ack <= 1'b0;
        repeat (2) @(posedge i_clock);
        chk({15'h0, wrap_irq}, 16'h0000);
        wr(timer16_pkg::ADDR_CNT_HI, 8'h05);
        // the tick lands on the same edge as the low byte write
        fork
            wr(timer16_pkg::ADDR_CNT_LO, 8'h50);
            pulse(1);
        join
        rdc(timer16_pkg::ADDR_CNT_LO, 16'h0550);
        wr(timer16_pkg::ADDR_CTRL_B, 8'h07);
        repeat (3)
        begin
            @(posedge i_clock);
            ext_pin <= 1'b1;
            repeat (4) @(posedge i_clock);
            ext_pin <= 1'b0;
            repeat (4) @(posedge i_clock);
        end
        wr(timer16_pkg::ADDR_CTRL_B, 8'h00);
        rdc(timer16_pkg::ADDR_CNT_LO, 16'h0553);
        wr(timer16_pkg::ADDR_CTRL_A, 8'h01);
        wr(timer16_pkg::ADDR_CTRL_B, 8'h02);
        i_cpu.wr16(timer16_pkg::ADDR_CNT_LO, 16'h00FD);
        pulse(2);
        chk({15'h0, top}, 16'h0001);
        pulse(1);
        rdc(timer16_pkg::ADDR_CNT_LO, 16'h00FE);
        wr(timer16_pkg::ADDR_CTRL_A, 8'h00);
        $display("test counting done");
        wr(timer16_pkg::ADDR_CTRL_B, 8'h40);
        i_cpu.wr16(timer16_pkg::ADDR_CNT_LO, 16'h1234);
        wr(timer16_pkg::ADDR_IRQ_EN, 8'h20);
        set_pin(1'b1, 8);
        rdf(8'h20);
        chk({15'h0, cap_irq}, 16'h0001);
        rdc(timer16_pkg::ADDR_CAP_LO, 16'h1234);
        wr(timer16_pkg::ADDR_FLAGS, 8'h00);
        rdf(8'h20);
        wr(timer16_pkg::ADDR_CTRL_B, 8'h00);
        i_cpu.wr16(timer16_pkg::ADDR_CNT_LO, 16'h4321);
        set_pin(1'b0, 8);
        rdc(timer16_pkg::ADDR_CAP_LO, 16'h4321);
        wr(timer16_pkg::ADDR_FLAGS, 8'h20);
        rdf(8'h00);
        set_pin(1'b1, 8);
        rdf(8'h00);
        set_pin(1'b0, 8);
        rdf(8'h20);
        @(posedge i_clock);
        cap_ack <= 1'b1;
        @(posedge i_clock);
        cap_ack <= 1'b0;
        rdf(8'h00);
        chk({15'h0, cap_irq}, 16'h0000);
        $display("test capture done");
        wr(timer16_pkg::ADDR_CTRL_B, 8'h40);
        wr(timer16_pkg::ADDR_CMP_CTRL, 8'h04);
        wr(timer16_pkg::ADDR_FLAGS, 8'h20);
        set_pin(1'b1, 8);
        rdf(8'h00);
        @(posedge i_clock);
        cmp_out <= 1'b1;
        repeat (8) @(posedge i_clock);
        rdf(8'h20);
        wr(timer16_pkg::ADDR_CMP_CTRL, 8'h00);
        $display("test source done");
        // filter on with the timer stopped: it runs on the system clock
        wr(timer16_pkg::ADDR_CTRL_B, 8'hC0);
        set_pin(1'b0, 12);
        wr(timer16_pkg::ADDR_FLAGS, 8'h20);
        set_pin(1'b1, 2);
        set_pin(1'b0, 12);
        rdf(8'h00);
        set_pin(1'b1, 12);
        rdf(8'h20);
        $display("test filter done");
        i_cpu.wr16(timer16_pkg::ADDR_CAP_LO, 16'hBEEF);
        rdc(timer16_pkg::ADDR_CAP_LO, 16'h4321);
        // mode is set before the top value is written
        wr(timer16_pkg::ADDR_CTRL_B, 8'h18);
        i_cpu.wr16(timer16_pkg::ADDR_CAP_LO, 16'hBEEF);
        rdc(timer16_pkg::ADDR_CAP_LO, 16'hBEEF);
        wr(timer16_pkg::ADDR_FLAGS, 8'h20);
        set_pin(1'b0, 8);
        set_pin(1'b1, 8);
        rdf(8'h00);
        $display("test top done");
        finish_test();
    end
endmodule : testbench
